//--- inc/irq_prio_pkg.sv
// Purpose: Constants for the peripheral interrupt enable and priority block
// Assumes: 32-bit Avalon-MM slave, word addressed by byte offset
// Notes: Only low byte of each word is implemented
package irq_prio_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SECOND = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PRIO_FIRST = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PRIO_SECOND = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'hC;
  localparam logic [REG_W-1:0] MASK_ENABLE_SECOND = 8'hA4;
  localparam logic [REG_W-1:0] MASK_PRIO_FIRST = 8'h77;
  localparam logic [REG_W-1:0] MASK_PRIO_SECOND = 8'hA4;
  localparam logic [REG_W-1:0] MASK_CONTROL = 8'h80;
  localparam logic [REG_W-1:0] RST_ENABLE_SECOND = 8'h00;
  localparam logic [REG_W-1:0] RST_PRIO_FIRST = 8'h77;
  localparam logic [REG_W-1:0] RST_PRIO_SECOND = 8'hA4;
  localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_USB = 5;
  localparam int BIT_VOLT = 2;
  localparam int BIT_ADC = 6;
  localparam int BIT_SER_RX = 5;
  localparam int BIT_SER_TX = 4;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_TMR_MATCH = 1;
  localparam int BIT_TMR_OVF = 0;
  localparam int BIT_PRIO_EN = 7;
  localparam int N_FIRST = 6;
  localparam int N_SECOND = 3;
  localparam logic [DATA_W-REG_W-1:0] READ_PAD = 24'h000000;
endpackage

//--- rtl/irq_mask_reg.sv
// Purpose: One masked 8-bit register with write strobe
// Assumes: Synchronous active-low reset
// Notes: Unimplemented bits stay at zero
`timescale 1ns/1ps
module irq_mask_reg #(
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic [7:0] RST = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);
  logic [7:0] value_q;
  wire [7:0] value_d = wr ? (wdata & MASK) : value_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) value_q <= RST & MASK;
    else value_q <= value_d;
  end
  assign value = value_q;
endmodule

//--- rtl/periph_irq_enable_priority.sv
// Purpose: Peripheral interrupt enable and priority registers
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: Priority outputs are qualified by the priority-levels enable
`timescale 1ns/1ps
module periph_irq_enable_priority (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [irq_prio_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [irq_prio_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic osc_fail_irq_en,
  output logic usb_irq_en,
  output logic volt_detect_irq_en,
  output logic priority_levels_enable,
  output logic [irq_prio_pkg::N_FIRST-1:0] first_src_high_prio,
  output logic [irq_prio_pkg::N_SECOND-1:0] second_src_high_prio
);
  // Accept on second cycle so readdata comes from a flop
  localparam int N_REGS = 4;
  localparam int IDX_EN2 = 0;
  localparam int IDX_PR1 = 1;
  localparam int IDX_PR2 = 2;
  localparam int IDX_CTL = 3;
  logic ack_q;
  logic wait_q;
  logic [irq_prio_pkg::DATA_W-1:0] rdata_q;
  logic osc_q, usb_q, volt_q, plev_q;
  logic [irq_prio_pkg::N_FIRST-1:0] hp1_q;
  logic [irq_prio_pkg::N_SECOND-1:0] hp2_q;
  logic [irq_prio_pkg::REG_W-1:0] reg_val [N_REGS];
  logic [7:0] en2, pr1, pr2, ctl;

  // Address decode, shared by write strobes, read mux and checks
  function automatic logic [N_REGS-1:0] decode_ofs(
    input logic [irq_prio_pkg::ADDR_W-1:0] a
  );
    logic [N_REGS-1:0] hit;
    hit = '0;
    hit[IDX_EN2] = (a == irq_prio_pkg::OFS_ENABLE_SECOND);
    hit[IDX_PR1] = (a == irq_prio_pkg::OFS_PRIO_FIRST);
    hit[IDX_PR2] = (a == irq_prio_pkg::OFS_PRIO_SECOND);
    hit[IDX_CTL] = (a == irq_prio_pkg::OFS_CONTROL);
    return hit;
  endfunction

  // Per-register constants for the loop below
  function automatic logic [irq_prio_pkg::REG_W-1:0] mask_of(input int idx);
    logic [irq_prio_pkg::REG_W-1:0] m;
    case (idx)
      IDX_EN2: m = irq_prio_pkg::MASK_ENABLE_SECOND;
      IDX_PR1: m = irq_prio_pkg::MASK_PRIO_FIRST;
      IDX_PR2: m = irq_prio_pkg::MASK_PRIO_SECOND;
      default: m = irq_prio_pkg::MASK_CONTROL;
    endcase
    return m;
  endfunction
  function automatic logic [irq_prio_pkg::REG_W-1:0] rst_of(input int idx);
    logic [irq_prio_pkg::REG_W-1:0] r;
    case (idx)
      IDX_EN2: r = irq_prio_pkg::RST_ENABLE_SECOND;
      IDX_PR1: r = irq_prio_pkg::RST_PRIO_FIRST;
      IDX_PR2: r = irq_prio_pkg::RST_PRIO_SECOND;
      default: r = irq_prio_pkg::RST_CONTROL;
    endcase
    return r;
  endfunction

  wire req = avs_read | avs_write;
  wire ack_d = req & ~ack_q;
  // Write lands on the edge that ends the waitrequest-low cycle, so a held request writes once
  wire wr_ok = avs_write & ack_q & avs_byteenable[0];
  wire [N_REGS-1:0] sel = decode_ofs(avs_address);
  wire [N_REGS-1:0] reg_wr = sel & {N_REGS{wr_ok}};
  // Unmapped addresses read zero, writes dropped
  wire [7:0] rsel = sel[IDX_EN2] ? en2 :
                    sel[IDX_PR1] ? pr1 :
                    sel[IDX_PR2] ? pr2 :
                    sel[IDX_CTL] ? ctl : 8'h00;
  wire [irq_prio_pkg::DATA_W-1:0] rdata_d = (avs_read & ~ack_q) ?
      {irq_prio_pkg::READ_PAD, rsel} : rdata_q;
  // One masked register per word; masks hold dead bits at zero
  generate
    for (genvar g = 0; g < N_REGS; g++) begin : g_reg
      irq_mask_reg #(
        .MASK(mask_of(g)),
        .RST(rst_of(g))
      ) u_reg (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr(reg_wr[g]),
        .wdata(avs_writedata[irq_prio_pkg::REG_W-1:0]),
        .value(reg_val[g])
      );
    end
  endgenerate
  assign en2 = reg_val[IDX_EN2];
  assign pr1 = reg_val[IDX_PR1];
  assign pr2 = reg_val[IDX_PR2];
  assign ctl = reg_val[IDX_CTL];
  wire plev = ctl[irq_prio_pkg::BIT_PRIO_EN];
  // Single-level mode treats every source as high priority
  wire [irq_prio_pkg::N_FIRST-1:0] hp1_raw = {pr1[irq_prio_pkg::BIT_ADC],
      pr1[irq_prio_pkg::BIT_SER_RX], pr1[irq_prio_pkg::BIT_SER_TX],
      pr1[irq_prio_pkg::BIT_CAPCMP], pr1[irq_prio_pkg::BIT_TMR_MATCH],
      pr1[irq_prio_pkg::BIT_TMR_OVF]};
  wire [irq_prio_pkg::N_SECOND-1:0] hp2_raw = {pr2[irq_prio_pkg::BIT_OSC_FAIL],
      pr2[irq_prio_pkg::BIT_USB], pr2[irq_prio_pkg::BIT_VOLT]};
  wire [irq_prio_pkg::N_FIRST-1:0] hp1_d = plev ? hp1_raw : {irq_prio_pkg::N_FIRST{1'b1}};
  wire [irq_prio_pkg::N_SECOND-1:0] hp2_d = plev ? hp2_raw : {irq_prio_pkg::N_SECOND{1'b1}};
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
      osc_q <= 1'b0;
      usb_q <= 1'b0;
      volt_q <= 1'b0;
      plev_q <= 1'b0;
      hp1_q <= '1;
      hp2_q <= '1;
    end else begin
      ack_q <= ack_d;
      wait_q <= ~ack_d;
      rdata_q <= rdata_d;
      osc_q <= en2[irq_prio_pkg::BIT_OSC_FAIL];
      usb_q <= en2[irq_prio_pkg::BIT_USB];
      volt_q <= en2[irq_prio_pkg::BIT_VOLT];
      plev_q <= plev;
      hp1_q <= hp1_d;
      hp2_q <= hp2_d;
    end
  end
  // Waitrequest high while idle too; legal for Avalon and keeps it a flop
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign osc_fail_irq_en = osc_q;
  assign usb_irq_en = usb_q;
  assign volt_detect_irq_en = volt_q;
  assign priority_levels_enable = plev_q;
  assign first_src_high_prio = hp1_q;
  assign second_src_high_prio = hp2_q;

  property p_unimpl_zero;
    @(posedge clk_sys) disable iff (!rstn)
      ((en2 & ~irq_prio_pkg::MASK_ENABLE_SECOND) == 8'h00) &&
      ((pr1 & ~irq_prio_pkg::MASK_PRIO_FIRST) == 8'h00) &&
      ((pr2 & ~irq_prio_pkg::MASK_PRIO_SECOND) == 8'h00) &&
      ((ctl & ~irq_prio_pkg::MASK_CONTROL) == 8'h00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");
  property p_read_pad;
    @(posedge clk_sys) disable iff (!rstn)
      avs_readdata[irq_prio_pkg::DATA_W-1:irq_prio_pkg::REG_W] == irq_prio_pkg::READ_PAD;
  endproperty
  a_read_pad: assert property (p_read_pad) else $error("upper read bits not zero");
  property p_en_write;
    @(posedge clk_sys) disable iff (!rstn)
      reg_wr[IDX_EN2] |=> ##1
        (osc_fail_irq_en == $past(avs_writedata[irq_prio_pkg::BIT_OSC_FAIL], 2)) &&
        (usb_irq_en == $past(avs_writedata[irq_prio_pkg::BIT_USB], 2));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write not seen");
  property p_volt_write;
    @(posedge clk_sys) disable iff (!rstn)
      reg_wr[IDX_EN2] |=> ##1
        (volt_detect_irq_en == $past(avs_writedata[irq_prio_pkg::BIT_VOLT], 2));
  endproperty
  a_volt_write: assert property (p_volt_write) else $error("voltage enable wrong");
  property p_single_level;
    @(posedge clk_sys) disable iff (!rstn)
      !priority_levels_enable |-> (first_src_high_prio == '1) &&
                                  (second_src_high_prio == '1);
  endproperty
  a_single_level: assert property (p_single_level) else $error("priority used when off");
  property p_first_map;
    @(posedge clk_sys) disable iff (!rstn)
      plev ##1 plev |-> first_src_high_prio == {$past(pr1[irq_prio_pkg::BIT_ADC]),
          $past(pr1[irq_prio_pkg::BIT_SER_RX]), $past(pr1[irq_prio_pkg::BIT_SER_TX]),
          $past(pr1[irq_prio_pkg::BIT_CAPCMP]), $past(pr1[irq_prio_pkg::BIT_TMR_MATCH]),
          $past(pr1[irq_prio_pkg::BIT_TMR_OVF])};
  endproperty
  a_first_map: assert property (p_first_map) else $error("first priority map wrong");
  property p_second_map;
    @(posedge clk_sys) disable iff (!rstn)
      plev ##1 plev |-> second_src_high_prio == {$past(pr2[irq_prio_pkg::BIT_OSC_FAIL]),
          $past(pr2[irq_prio_pkg::BIT_USB]), $past(pr2[irq_prio_pkg::BIT_VOLT])};
  endproperty
  a_second_map: assert property (p_second_map) else $error("second priority map wrong");
  property p_reset_vals;
    @(posedge clk_sys) $rose(rstn) |-> (en2 == irq_prio_pkg::RST_ENABLE_SECOND) &&
      (pr1 == irq_prio_pkg::RST_PRIO_FIRST) && (pr2 == irq_prio_pkg::RST_PRIO_SECOND) &&
      (ctl == irq_prio_pkg::RST_CONTROL);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_reset_out;
    @(posedge clk_sys) !rstn |=> avs_waitrequest && !osc_fail_irq_en && !usb_irq_en &&
      !volt_detect_irq_en && !priority_levels_enable && (&first_src_high_prio) &&
      (&second_src_high_prio);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
  property p_levels;
    @(posedge clk_sys) disable iff (!rstn)
      reg_wr[IDX_CTL] |=> ##1
        priority_levels_enable == $past(avs_writedata[irq_prio_pkg::BIT_PRIO_EN], 2);
  endproperty
  a_levels: assert property (p_levels) else $error("levels enable wrong");
  property p_byte_drop;
    @(posedge clk_sys) disable iff (!rstn)
      (avs_write && !avs_byteenable[0]) |=> ##1
        $stable(en2) && $stable(pr1) && $stable(pr2) && $stable(ctl);
  endproperty
  a_byte_drop: assert property (p_byte_drop) else $error("masked write changed a register");
  property p_unmapped;
    @(posedge clk_sys) disable iff (!rstn)
      (avs_write && (decode_ofs(avs_address) == '0)) |=> ##1
        $stable(en2) && $stable(pr1) && $stable(pr2) && $stable(ctl);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");
  property p_wait_one;
    @(posedge clk_sys) disable iff (!rstn)
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");
endmodule

//--- test/irq_sink_model.sv
// Purpose: Processor side that sorts pending second-group sources into levels
// Assumes: Pending inputs are plain levels from the sources
// Notes: Enables gate sources before any level is chosen
`timescale 1ns/1ps
module irq_sink_model (
  input wire logic [2:0] pend,
  input wire logic [2:0] en,
  input wire logic [2:0] high,
  output logic hi_req,
  output logic lo_req
);
  assign hi_req = |(pend & en & high);
  assign lo_req = |(pend & en & ~high);
endmodule

//--- test/tb.sv
// Purpose: Self-checking bench for the enable and priority registers
// Assumes: One answer per request, waitrequest low for one cycle
// Notes: Offset 0x6 stands for an unmapped place
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rng = 32'h8450, q [$];
  logic avs_waitrequest, osc, usb, volt, lev, hi_req, lo_req, lv;
  logic [5:0] prio1;
  logic [2:0] prio2, hp, ev;
  logic [9:0] xp;
  logic [2:0] pend = 3'h0;
  logic [7:0] e, p1, p2;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  periph_irq_enable_priority u_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_fail_irq_en(osc), .usb_irq_en(usb),
    .volt_detect_irq_en(volt), .priority_levels_enable(lev), .first_src_high_prio(prio1),
    .second_src_high_prio(prio2));
  irq_sink_model u_sink (.pend(pend), .en({osc, usb, volt}), .high(prio2), .hi_req(hi_req),
    .lo_req(lo_req));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Request held until waitrequest low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic chk_rst;
    rreg(4'h0, 32'h0);
    rreg(4'h4, 32'h77);
    rreg(4'h8, 32'hA4);
    rreg(4'hC, 32'h0);
    check({osc, usb, volt, lev, prio1, prio2}, 32'h1FF);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, q.pop_front());
    if (cyc > 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk_rst();
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      lv = i[0];
      bus(1'b1, 4'hC, {rng[31:8], lv, rng[6:0]}, 4'hF);
      rng = xs(rng);
      e = rng[7:0];
      bus(1'b1, 4'h0, rng, 4'hF);
      bus(1'b1, 4'h0, ~rng, 4'hE);
      rng = xs(rng);
      p1 = rng[7:0];
      bus(1'b1, 4'h4, rng, 4'hF);
      rng = xs(rng);
      p2 = rng[7:0];
      bus(1'b1, 4'h8, rng, 4'hF);
      bus(1'b1, 4'h6, 32'hFF, 4'hF);
      rreg(4'h6, 32'h0);
      rreg(4'h0, {24'h0, e & 8'hA4});
      rreg(4'h4, {24'h0, p1 & 8'h77});
      rreg(4'h8, {24'h0, p2 & 8'hA4});
      rreg(4'hC, {24'h0, lv, 7'h0});
      check({osc, usb, volt}, {e[7], e[5], e[2]});
      xp = lv ? {1'b1, p1[6:4], p1[2:0], p2[7], p2[5], p2[2]} : 10'h1FF;
      check({lev, prio1, prio2}, xp);
      hp = lv ? {p2[7], p2[5], p2[2]} : 3'h7;
      ev = {e[7], e[5], e[2]};
      pend <= rng[10:8];
      @(posedge clk_sys);
      check({hi_req, lo_req}, {|(pend & ev & hp), |(pend & ev & ~hp)});
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk_rst();
    end_sim();
  end
endmodule
